//--- test/led_status_indicator_tb_top.sv
`timescale 1ns/10ps
module led_status_indicator_tb_top;
  import lsi_pkg::*;
  localparam int SH = 40;
  localparam int RS = 8;
  localparam int FL = 3;
  localparam int WIN = 12 * SH;
  typedef struct {
    logic [7:0]  md;
    logic [7:0]  fl;
    logic        usb;
    logic        can;
    int          sel;
    logic [31:0] exp;
  } lsi_row_s;
  lsi_row_s rows [20] = '{
    '{8'h08, 8'h00, 1, 0, 1, WIN},
    '{8'h00, 8'h00, 1, 0, 0, WIN/2},
    '{8'h00, 8'h00, 1, 0, 2, 0},
    '{8'h08, 8'h01, 1, 0, 1, WIN/2},
    '{8'h08, 8'h01, 1, 0, 3, WIN/2},
    '{8'h18, 8'h00, 1, 0, 1, WIN/12},
    '{8'h18, 8'h00, 1, 0, 11, WIN/12},
    '{8'h28, 8'h00, 1, 0, 1, WIN},
    '{8'h28, 8'h02, 1, 0, 2, WIN/2},
    '{8'h01, 8'h00, 0, 1, 1, WIN},
    '{8'h02, 8'h00, 0, 1, 1, WIN/2},
    '{8'h03, 8'h00, 0, 1, 1, WIN/2},
    '{8'h01, 8'h02, 0, 1, 0, WIN/2},
    '{8'h01, 8'h04, 0, 1, 3, WIN/2},
    '{8'h01, 8'h08, 0, 1, 0, WIN},
    '{8'h01, 8'h08, 0, 1, 10, WIN/2},
    '{8'h01, 8'h10, 0, 1, 0, WIN},
    '{8'h01, 8'h20, 0, 1, 6, WIN/2},
    '{8'h09, 8'h00, 1, 1, 1, WIN},
    '{8'h48, 8'h00, 1, 0, 1, WIN}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic usb = 1'b1, can = 1'b0, clr = 1'b0, en = 1'b0;
  lsi_chan_s [4:0] chan = '0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, lmode;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire lsi_led_s power_indicator;
  wire lsi_led_s [4:0] trf;
  logic [15:0] lit [12];
  logic [1:0] r;
  logic [31:0] d, n;
  int failures = 0;
  int samples_checked = 0;

  always #25 clk = ~clk;

  lsi_top #(.SLOW_HALF(SH), .FAST_HALF(10), .FLASH_LEN(FL), .RUN_STEP(RS))
    lsi_top_inst (.i_core_clk(clk), .i_arst_n(rst_n), .i_usb_pwr(usb),
    .i_can_pwr(can), .i_chan(chan), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_logger_mode(lmode), .o_power_indicator(power_indicator), .o_traffic(trf));
  lsi_led_obs lsi_led_obs_inst (.i_clk(clk), .i_clr(clr), .i_en(en),
    .i_led({trf, power_indicator}), .o_lit(lit));

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, want);
    end
  endtask : chk

  // Ready is sampled at the falling edge because it is combinational and
  // drops right after the edge that takes the item.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, pb;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      pa = awready && awvalid;
      pw = wready && wvalid;
      pb = bvalid;
      r = bresp;
      @(posedge clk);
      if (pa) awvalid <= 1'b0;
      if (pw) wvalid <= 1'b0;
    end while (!pb);
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic pa, pv;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      pa = arready && arvalid;
      pv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (pa) arvalid <= 1'b0;
    end while (!pv);
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic watch(input int s, input int c);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    en <= 1'b1;
    repeat (c) @(posedge clk);
    en <= 1'b0;
    @(negedge clk);
    n = 32'(lit[s]);
    @(posedge clk);
  endtask : watch

  task automatic pulse(input int c, input int b);
    @(posedge clk);
    chan[c][b] <= 1'b1;
    @(posedge clk);
    chan[c][b] <= 1'b0;
  endtask : pulse

  task automatic stop_test();
    $display("comparisons %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_MODE);
    chk(d, MODE_RESET);
    rd(OFS_FAULT);
    chk(d, FAULT_RESET);
    rd(8'h40);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, ZERO_WORD);
    wr(8'h44, 32'h0000_0001);
    chk(32'(r), 32'(RESP_SLVERR));
    foreach (rows[k]) begin
      usb <= rows[k].usb;
      can <= rows[k].can;
      wr(OFS_MODE, {24'h00_0000, rows[k].md});
      wr(OFS_FAULT, {24'h00_0000, rows[k].fl});
      repeat (20) @(posedge clk);
      watch(rows[k].sel, WIN);
      chk(n, rows[k].exp);
    end
    // A running script with an override takes green away.
    wr(OFS_OVR_EN, 32'h0000_0001);
    wr(OFS_OVR_G, 32'h0000_0000);
    repeat (20) @(posedge clk);
    watch(1, WIN);
    chk(n, 0);
    // Overriding channel 0 red lights it while the script runs.
    wr(OFS_OVR_EN, 32'h0000_0008);
    wr(OFS_OVR_R, 32'h0000_0008);
    repeat (20) @(posedge clk);
    watch(2, WIN);
    chk(n, WIN);
    rd(OFS_MODE);
    chk(d, 32'h0000_0048);
    chk(32'(r), 32'(RESP_OKAY));
    wr(OFS_MODE, 32'h0000_0008);
    repeat (20) @(posedge clk);
    watch(1, WIN);
    chk(n, WIN);
    for (int c = 0; c < 5; c++) begin
      for (int b = 3; b < 5; b++) begin
        fork
          watch(2 + 2 * c + (b == 4 ? 1 : 0), 20);
          pulse(c, b);
        join
        chk(n, FL);
      end
    end
    chan[1][2] <= 1'b1;
    repeat (20) @(posedge clk);
    watch(4, WIN);
    chk(n, WIN / 2);
    chan[1][2] <= 1'b0;
    pulse(2, 1);
    watch(6, 100);
    chk(n, 100);
    rd(OFS_CHSTAT);
    chk(d, 32'h0000_0004);
    pulse(2, 0);
    repeat (5) @(posedge clk);
    watch(6, 100);
    chk(n, 0);
    // Idle interface view: green power, dark traffic, not logging.
    rd(OFS_STATUS);
    chk(d, 32'h0000_0004);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_MODE);
    chk(d, MODE_RESET);
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : led_status_indicator_tb_top

//--- test/lsi_led_obs.sv
`timescale 1ns/10ps
// An operator watching the lamps: it counts, for each of the twelve
// colours, the clock edges at which that colour is lit.
module lsi_led_obs (
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  input  wire logic        i_en,
  input  wire logic [11:0] i_led,
  output logic [15:0]      o_lit [12]
);
  // Power takes two colours and each channel two more.
  // Sampling every edge means even a brief flash is seen.
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 12; k++) begin
      if (i_clr) o_lit[k] <= '0;
      else if (i_en && i_led[k] === 1'b1) o_lit[k] <= o_lit[k] + 16'h0001;
    end
  end
endmodule : lsi_led_obs

//--- test/lsi_top_props.sv
`timescale 1ns/10ps
module lsi_top_props #(
  parameter int SLOW_HALF = 40,
  parameter int FAST_HALF = 10
) (
  input wire logic                     i_core_clk,
  input wire logic                     i_arst_n,
  input wire logic                     i_usb_pwr,
  input wire logic                     i_can_pwr,
  input wire lsi_pkg::lsi_chan_s [4:0] i_chan,
  input wire logic [7:0]               i_awaddr,
  input wire logic                     i_awvalid,
  input wire logic                     o_awready,
  input wire logic [31:0]              i_wdata,
  input wire logic                     i_wvalid,
  input wire logic                     o_wready,
  input wire logic [1:0]               o_bresp,
  input wire logic                     o_bvalid,
  input wire logic                     o_logger_mode,
  input wire lsi_pkg::lsi_led_s        o_power_indicator,
  input wire lsi_pkg::lsi_led_s [4:0]  o_traffic
);
  import lsi_pkg::*;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [6:0]  md;
  logic [5:0]  fl;
  logic        bq;
  logic [6:0]  st;
  logic [6:0]  rr;
  logic [6:0]  ry;
  // The shadow copies only follow accepted writes, so a refused one is
  // never mistaken for a mode change.
  wire ok = o_bvalid && !bq && o_bresp == RESP_OKAY;
  wire q = st >= 7'h08;
  wire q2 = st >= 7'h64;
  wire norm = i_usb_pwr && md == 7'h08 && fl == '0;
  wire wait_usb = i_usb_pwr && md[6:3] == '0 && fl == '0;
  wire tool = md[4] && !md[6];
  wire disk = md[5] && !md[4] && !md[6];

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wa <= '0;
      wd <= '0;
      md <= '0;
      fl <= '0;
      bq <= 1'b0;
    end else begin
      bq <= o_bvalid;
      if (i_awvalid && o_awready) wa <= i_awaddr;
      if (i_wvalid && o_wready) wd <= i_wdata;
      if (ok && wa == OFS_MODE) md <= wd[6:0];
      if (ok && wa == OFS_FAULT) fl <= wd[5:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) st <= '0;
    else if (ok || $changed(i_usb_pwr) || $changed(i_can_pwr)) st <= '0;
    else if (st != 7'h7F) st <= st + 7'h01;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rr <= '0;
      ry <= '0;
    end else begin
      rr <= $stable(o_traffic[0].col_b) ? rr + 7'h01 : 7'h01;
      ry <= $stable(o_power_indicator.col_b) ? ry + 7'h01 : 7'h01;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  a_logger_mode_def: assert property (
    o_logger_mode == (i_can_pwr && !i_usb_pwr))
    else $error("logger mode does not follow the supplies");
  a_usb_wait_dark: assert property (
    q && wait_usb |-> o_traffic == '0 && !o_power_indicator.col_a)
    else $error("traffic or green lit while awaiting configuration");
  a_ready_green: assert property (
    q && norm |-> o_power_indicator == 2'h2)
    else $error("power not steady green in normal interface mode");
  a_run_one_hot: assert property (
    q && tool |-> $onehot({o_traffic, o_power_indicator}))
    else $error("running pattern lights more than one colour");
  a_run_order: assert property (
    q && tool && $fell(o_power_indicator.col_a)
    |-> o_power_indicator.col_b)
    else $error("running pattern skips power yellow");
  a_disk_view: assert property (
    q && disk |-> o_power_indicator == 2'h2 &&
    o_traffic == (o_traffic[0].col_b ? 10'h155 : 10'h000))
    else $error("disk activity view wrong or red not uniform");
  a_fast_half_len: assert property (
    q2 && disk && $fell(o_traffic[0].col_b) |-> rr == FAST_HALF)
    else $error("fast blink on phase has wrong length");
  a_slow_half_len: assert property (
    q2 && wait_usb && $fell(o_power_indicator.col_b) |-> ry == SLOW_HALF)
    else $error("slow blink on phase has wrong length");
  a_frame_flash: assert property (
    q && norm && i_chan[0].frame |-> ##[1:2] o_traffic[0].col_a)
    else $error("no yellow flash after a frame");
  a_overrun_red: assert property (
    q && norm && i_chan[2].overrun |-> ##2 o_traffic[2].col_b [*4])
    else $error("overrun red not held");

  c_running: cover property (q && tool && $fell(o_power_indicator.col_a));
  c_disk_blink: cover property (q2 && disk && $fell(o_traffic[0].col_b));
  c_overrun: cover property (q && norm && i_chan[2].overrun);
endmodule : lsi_top_props

bind lsi_top lsi_top_props #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF))
  lsi_top_props_inst (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_usb_pwr(i_usb_pwr),
  .i_can_pwr(i_can_pwr), .i_chan(i_chan), .i_awaddr(i_awaddr),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
  .o_bvalid(o_bvalid), .o_logger_mode(o_logger_mode),
  .o_power_indicator(o_power_indicator), .o_traffic(o_traffic));

//--- verilog/lsi_pkg.sv
package lsi_pkg;

  localparam int NUM_CHAN = 5;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_FAULT  = 8'h04;
  localparam logic [7:0] OFS_OVR_EN = 8'h08;
  localparam logic [7:0] OFS_OVR_G  = 8'h0C;
  localparam logic [7:0] OFS_OVR_Y  = 8'h10;
  localparam logic [7:0] OFS_OVR_R  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CHSTAT = 8'h1C;

  // Fields of the mode register.
  localparam int MODE_STATE_LSB = 0;
  localparam int MODE_STATE_W   = 3;
  localparam int MODE_USB_CFG   = 3;
  localparam int MODE_TOOL      = 4;
  localparam int MODE_DISK_ACT  = 5;
  localparam int MODE_SCRIPT    = 6;

  // Fields of the fault register.
  localparam int FLT_FW_CFG  = 0;
  localparam int FLT_FW_HW   = 1;
  localparam int FLT_BATTERY = 2;
  localparam int FLT_DISK    = 3;
  localparam int FLT_CONFIG  = 4;
  localparam int FLT_SCRIPT  = 5;
  localparam int FLT_W       = 6;

  localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Pattern timing in milliseconds, then in cycles of the 20 MHz clock.
  localparam int CLK_HZ      = 20_000_000;
  localparam int SLOW_HALF_MS = 500;
  localparam int FAST_HALF_MS = 125;
  localparam int FLASH_MS     = 20;
  localparam int RUN_STEP_MS  = 100;
  localparam int SLOW_HALF_CYC = SLOW_HALF_MS * (CLK_HZ / 1000);
  localparam int FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC     = FLASH_MS * (CLK_HZ / 1000);
  localparam int RUN_STEP_CYC  = RUN_STEP_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    LSI_ST_IDLE    = 3'b000,
    LSI_ST_ARMED   = 3'b001,
    LSI_ST_ACTIVE  = 3'b010,
    LSI_ST_STOPPED = 3'b011
  } lsi_log_e;

  // One CAN channel's status events and levels.
  typedef struct packed {
    logic frame;
    logic err_frame;
    logic err_passive;
    logic overrun;
    logic bus_off;
  } lsi_chan_s;

  // One dual-colour indicator: first and second colour.
  typedef struct packed {
    logic col_a;
    logic col_b;
  } lsi_led_s;

endpackage : lsi_pkg

//--- verilog/lsi_top.sv
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module lsi_top #(
  parameter int SLOW_HALF = lsi_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = lsi_pkg::FAST_HALF_CYC,
  parameter int FLASH_LEN = lsi_pkg::FLASH_CYC,
  parameter int RUN_STEP  = lsi_pkg::RUN_STEP_CYC
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_arst_n,
  input  wire logic                          i_usb_pwr,
  input  wire logic                          i_can_pwr,
  input  wire lsi_pkg::lsi_chan_s [4:0]      i_chan,
  input  wire logic [7:0]                    i_awaddr,
  input  wire logic                          i_awvalid,
  output logic                               o_awready,
  input  wire logic [31:0]                   i_wdata,
  input  wire logic [3:0]                    i_wstrb,
  input  wire logic                          i_wvalid,
  output logic                               o_wready,
  output logic [1:0]                         o_bresp,
  output logic                               o_bvalid,
  input  wire logic                          i_bready,
  input  wire logic [7:0]                    i_araddr,
  input  wire logic                          i_arvalid,
  output logic                               o_arready,
  output logic [31:0]                        o_rdata,
  output logic [1:0]                         o_rresp,
  output logic                               o_rvalid,
  input  wire logic                          i_rready,
  output logic                               o_logger_mode,
  output lsi_pkg::lsi_led_s                  o_power_indicator,
  output lsi_pkg::lsi_led_s [4:0]            o_traffic
);
  import lsi_pkg::*;

  localparam int NLED = 2 + 2 * NUM_CHAN;

  logic [31:0]         mode_reg;
  logic [31:0]         fault_reg;
  logic [NLED-1:0]     ovr_en;
  logic [NLED-1:0]     ovr_g;
  logic [NLED-1:0]     ovr_y;
  logic [NLED-1:0]     ovr_r;
  logic [NUM_CHAN-1:0] overrun_hold;
  logic [NUM_CHAN-1:0] flash_y;
  logic [NUM_CHAN-1:0] flash_r;
  logic [31:0]         fl_cnt_y [NUM_CHAN];
  logic [31:0]         fl_cnt_r [NUM_CHAN];
  logic [31:0]         slow_cnt;
  logic [31:0]         fast_cnt;
  logic [31:0]         run_cnt;
  logic                slow_ph;
  logic                fast_ph;
  logic [3:0]          run_pos;
  logic                logger;
  logic                aw_held;
  logic                w_held;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  lsi_led_s            next_pwr;
  lsi_led_s [4:0]      next_trf;

  // Strictly shorter fast half-period is required for distinct patterns.
  if (FAST_HALF >= SLOW_HALF) begin : g_bad_timing
    $error("Fast half period must be shorter than slow half period.");
  end

  // Prescalers for the shared pattern phases.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slow_cnt <= ZERO_WORD;
      slow_ph  <= 1'b0;
    end else if (slow_cnt >= 32'(SLOW_HALF - 1)) begin
      slow_cnt <= ZERO_WORD;
      slow_ph  <= ~slow_ph;
    end else begin
      slow_cnt <= slow_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fast_cnt <= ZERO_WORD;
      fast_ph  <= 1'b0;
    end else if (fast_cnt >= 32'(FAST_HALF - 1)) begin
      fast_cnt <= ZERO_WORD;
      fast_ph  <= ~fast_ph;
    end else begin
      fast_cnt <= fast_cnt + 32'h0000_0001;
    end
  end

  // Running position walks power green, power yellow, then channel pairs.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_cnt <= ZERO_WORD;
      run_pos <= 4'h0;
    end else if (run_cnt >= 32'(RUN_STEP - 1)) begin
      run_cnt <= ZERO_WORD;
      run_pos <= (run_pos == 4'(NLED - 1)) ? 4'h0 : run_pos + 4'h1;
    end else begin
      run_cnt <= run_cnt + 32'h0000_0001;
    end
  end

  // A fresh event restarts the flash, so a stream of events stays lit.
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_flash
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        fl_cnt_y[c] <= ZERO_WORD;
      end else if (i_chan[c].frame) begin
        fl_cnt_y[c] <= 32'(FLASH_LEN);
      end else if (fl_cnt_y[c] != ZERO_WORD) begin
        fl_cnt_y[c] <= fl_cnt_y[c] - 32'h0000_0001;
      end
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        fl_cnt_r[c] <= ZERO_WORD;
      end else if (i_chan[c].err_frame) begin
        fl_cnt_r[c] <= 32'(FLASH_LEN);
      end else if (fl_cnt_r[c] != ZERO_WORD) begin
        fl_cnt_r[c] <= fl_cnt_r[c] - 32'h0000_0001;
      end
    end
    assign flash_y[c] = (fl_cnt_y[c] != ZERO_WORD);
    assign flash_r[c] = (fl_cnt_r[c] != ZERO_WORD);
    // Overrun latches; bus-off releases it and a coincident overrun wins.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        overrun_hold[c] <= 1'b0;
      end else if (i_chan[c].overrun) begin
        overrun_hold[c] <= 1'b1;
      end else if (i_chan[c].bus_off) begin
        overrun_hold[c] <= 1'b0;
      end
    end
  end

  assign logger        = i_can_pwr & ~i_usb_pwr;
  assign o_logger_mode = logger;

  // Indication priority: tool, disk activity, device faults, state.
  always_comb begin
    lsi_log_e st;
    logic     any_flt;
    st       = lsi_log_e'(mode_reg[MODE_STATE_LSB +: MODE_STATE_W]);
    any_flt  = 1'b0;
    next_pwr = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      next_trf[c] = '0;
    end
    if (mode_reg[MODE_TOOL]) begin
      next_pwr.col_a = (run_pos == 4'h0);
      next_pwr.col_b = (run_pos == 4'h1);
      for (int c = 0; c < NUM_CHAN; c++) begin
        next_trf[c].col_a = (run_pos == 4'(2 + 2 * c));
        next_trf[c].col_b = (run_pos == 4'(3 + 2 * c));
      end
    end else if (mode_reg[MODE_DISK_ACT]) begin
      next_pwr.col_a = 1'b1;
      for (int c = 0; c < NUM_CHAN; c++) begin
        next_trf[c].col_b = fast_ph;
      end
    end else if (!logger && fault_reg[FLT_FW_CFG]) begin
      any_flt        = 1'b1;
      next_pwr.col_a = slow_ph;
      next_pwr.col_b = ~slow_ph;
      for (int c = 0; c < NUM_CHAN; c++) begin
        next_trf[c].col_a = slow_ph;
        next_trf[c].col_b = ~slow_ph;
      end
    end else if (!logger && !mode_reg[MODE_USB_CFG]) begin
      next_pwr.col_b = slow_ph;
      any_flt        = 1'b1;
    end else if (logger
                 && (fault_reg[FLT_FW_HW] | fault_reg[FLT_BATTERY])) begin
      any_flt        = 1'b1;
      next_pwr.col_a = fast_ph;
      next_pwr.col_b = ~fast_ph;
      for (int c = 0; c < NUM_CHAN; c++) begin
        next_trf[c].col_a = fault_reg[FLT_FW_HW] ? fast_ph : slow_ph;
        next_trf[c].col_b = fault_reg[FLT_FW_HW] ? ~fast_ph : ~slow_ph;
      end
    end else if (logger && fault_reg[FLT_DISK]) begin
      any_flt        = 1'b1;
      next_pwr.col_b = 1'b1;
      for (int c = 0; c < NUM_CHAN; c++) begin
        next_trf[c].col_b = slow_ph;
      end
    end else if (logger
                 && (fault_reg[FLT_CONFIG] | fault_reg[FLT_SCRIPT])) begin
      any_flt        = 1'b1;
      next_pwr.col_b = 1'b1;
      for (int c = 0; c < NUM_CHAN; c++) begin
        next_trf[c].col_b = fast_ph;
      end
    end else begin
      if (!logger) begin
        next_pwr.col_a = 1'b1;
      end else begin
        case (st)
          LSI_ST_ARMED:   next_pwr.col_a = 1'b1;
          LSI_ST_ACTIVE:  next_pwr.col_a = fast_ph;
          LSI_ST_STOPPED: next_pwr.col_a = slow_ph;
          default:        next_pwr.col_a = 1'b0;
        endcase
      end
    end
    if (!any_flt && !mode_reg[MODE_TOOL] && !mode_reg[MODE_DISK_ACT]) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        next_trf[c].col_a = flash_y[c] & ~overrun_hold[c];
        next_trf[c].col_b = overrun_hold[c] | flash_r[c]
                          | (i_chan[c].err_passive & fast_ph);
      end
    end
    // Script overrides only act while a script runs.
    if (mode_reg[MODE_SCRIPT]) begin
      if (ovr_en[0]) begin
        next_pwr.col_a = ovr_g[0];
      end
      if (ovr_en[1]) begin
        next_pwr.col_b = ovr_y[1];
      end
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (ovr_en[2 + 2 * c]) begin
          next_trf[c].col_a = ovr_y[2 + 2 * c];
        end
        if (ovr_en[3 + 2 * c]) begin
          next_trf[c].col_b = ovr_r[3 + 2 * c];
        end
      end
    end
  end

  // Registered indicator outputs.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_power_indicator <= '0;
      o_traffic         <= '0;
    end else begin
      o_power_indicator <= next_pwr;
      o_traffic         <= next_trf;
    end
  end

  // AXI4-Lite write path: address and data may arrive in either order.
  assign o_awready = ~aw_held & ~o_bvalid;
  assign o_wready  = ~w_held & ~o_bvalid;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= ZERO_WORD;
      w_strb  <= 4'h0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  logic        wr_go;
  logic [31:0] ovr_en_w;
  logic [31:0] ovr_g_w;
  logic [31:0] ovr_y_w;
  logic [31:0] ovr_r_w;
  assign wr_go    = aw_held & w_held;
  assign ovr_en_w = merge({20'h0_0000, ovr_en}, w_data, w_strb);
  assign ovr_g_w  = merge({20'h0_0000, ovr_g}, w_data, w_strb);
  assign ovr_y_w  = merge({20'h0_0000, ovr_y}, w_data, w_strb);
  assign ovr_r_w  = merge({20'h0_0000, ovr_r}, w_data, w_strb);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg  <= MODE_RESET;
      fault_reg <= FAULT_RESET;
      ovr_en    <= '0;
      ovr_g     <= '0;
      ovr_y     <= '0;
      ovr_r     <= '0;
    end else if (wr_go) begin
      case (aw_addr)
        OFS_MODE:   mode_reg  <= merge(mode_reg, w_data, w_strb)
                                 & 32'h0000_007F;
        OFS_FAULT:  fault_reg <= merge(fault_reg, w_data, w_strb)
                                 & 32'h0000_003F;
        OFS_OVR_EN: ovr_en    <= ovr_en_w[NLED-1:0];
        OFS_OVR_G:  ovr_g     <= ovr_g_w[NLED-1:0];
        OFS_OVR_Y:  ovr_y     <= ovr_y_w[NLED-1:0];
        OFS_OVR_R:  ovr_r     <= ovr_r_w[NLED-1:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp  <= (aw_addr <= OFS_OVR_R && aw_addr[1:0] == 2'b00)
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Read path answers one cycle after the address is taken.
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= ZERO_WORD;
      o_rresp  <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp  <= RESP_OKAY;
      case (i_araddr)
        OFS_MODE:   o_rdata <= mode_reg;
        OFS_FAULT:  o_rdata <= fault_reg;
        OFS_OVR_EN: o_rdata <= {20'h0_0000, ovr_en};
        OFS_OVR_G:  o_rdata <= {20'h0_0000, ovr_g};
        OFS_OVR_Y:  o_rdata <= {20'h0_0000, ovr_y};
        OFS_OVR_R:  o_rdata <= {20'h0_0000, ovr_r};
        OFS_STATUS: o_rdata <= {19'h0_0000, o_traffic, o_power_indicator,
                                logger};
        OFS_CHSTAT: o_rdata <= {27'h000_0000, overrun_hold};
        default: begin
          o_rdata <= ZERO_WORD;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule : lsi_top
